/* File: reliability_pkg.sv */
// Constants, field layouts and carrier types for the reliability supervisor.
// Assumes a single 250 MHz register clock; all long times derive from it.
package reliability_pkg;

  // ------
  // Timing
  // ------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int US_NS           = 1000;
  localparam int US_CYCLES       = US_NS / CLK_PERIOD_NS;
  localparam int MS_US           = 1000;
  localparam int MAIN_TIMEOUT_MS = 5000;
  localparam int WARN_LEAD_MS    = 600;
  localparam int INIT_TIMEOUT_MS = 100;

  // ------
  // Backup stack and CRC
  // ------
  localparam int              STACK_DEPTH = 16;
  localparam int              CRC_W       = 12;
  localparam logic [11:0]     CRC12_POLY  = 12'h80F;

  // ------
  // Register offsets (byte addresses)
  // ------
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_STACK_ADDR = 8'h08;
  localparam logic [7:0] OFS_STACK_DATA = 8'h0C;
  localparam logic [7:0] OFS_CRC_WORD   = 8'h10;
  localparam logic [7:0] OFS_WAKE_WIDTH = 8'h14;
  localparam logic [7:0] OFS_THRESH     = 8'h18;
  localparam logic [7:0] OFS_CNT_RX     = 8'h1C;
  localparam logic [7:0] OFS_CNT_CORR   = 8'h20;
  localparam logic [7:0] OFS_CNT_ERR    = 8'h24;

  // Control bits (write-one actions)
  localparam int CTRL_WD_KICK   = 0;
  localparam int CTRL_CRC_CHECK = 1;
  localparam int CTRL_CRC_CALC  = 2;
  localparam int CTRL_COPY_REGS = 3;

  // Status bits
  localparam int STS_CRC_PASS  = 0;
  localparam int STS_CRC_FAIL  = 1;
  localparam int STS_CALC_DONE = 2;
  localparam int STS_WD_WARN   = 3;
  localparam int STS_CRC_BUSY  = 4;
  localparam int STS_MAIN_ARM  = 5;
  localparam int STS_WD_ACTIVE = 6;

  // Reset values
  localparam logic [15:0] WAKE_WIDTH_RST = 16'h03E8;
  localparam logic [7:0]  THR_ERR_RST    = 8'h04;
  localparam logic [7:0]  THR_RETX_RST   = 8'h04;

  // ------
  // Carriers
  // ------
  typedef struct packed {
    logic carrier_ok;
    logic clock_ok;
    logic wake_valid;
    logic start_found;
  } wake_in_t;

  typedef struct packed {
    logic mac_power_on;
    logic mac_started;
    logic xtal_fail;
  } init_in_t;

  typedef struct packed {
    logic       link_up;
    logic       idle;
    logic       header_rx;
    logic       spi_access;
    logic       blk_valid;
    logic [7:0] blk_byte;
    logic       blk_last;
    logic       blk_corrected;
    logic       pkt_end;
    logic [7:0] retx;
  } link_in_t;

  typedef struct packed {
    logic wake_rx_off;
    logic sleep_req;
    logic restart_req;
    logic link_shutdown;
    logic wd_warn_irq;
    logic lq_irq;
    logic blk_ack_valid;
    logic blk_ack_ok;
    logic crc_error;
    logic wd_active;
  } sup_out_t;

  typedef enum logic [1:0] {
    CRC_IDLE = 2'b00,
    CRC_RUN  = 2'b01,
    CRC_EVAL = 2'b10
  } crc_state_t;

endpackage : reliability_pkg

/* File: crc_engine.sv */
// Byte-serial CRC register, MSB first, zero initial value.
// Assumes the caller presents one byte per cycle with valid.
`timescale 1ns/100ps
module crc_engine #(
  parameter int          WIDTH = 12,
  parameter logic [11:0] POLY  = 12'h80F
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             init,
  input  wire logic             valid,
  input  wire logic [7:0]       data,
  output logic      [WIDTH-1:0] crc
);

  typedef struct packed {
    logic [WIDTH-1:0] crc;
  } crc_st_t;

  crc_st_t st, next_st;

  // Eight shift steps per byte
  function automatic logic [WIDTH-1:0] step(input logic [WIDTH-1:0] c, input logic [7:0] d);
    logic [WIDTH-1:0] r;
    logic             fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[WIDTH-1] ^ d[i];
      r  = {r[WIDTH-2:0], 1'b0} ^ (fb ? POLY[WIDTH-1:0] : '0);
    end
    return r;
  endfunction : step

  // Init restarts from zero, folding in a byte if one comes with it
  always_comb begin
    next_st = st;
    if (init) begin
      next_st.crc = valid ? step('0, data) : '0;
    end else if (valid) begin
      next_st.crc = step(st.crc, data);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign crc = st.crc;

endmodule : crc_engine

/* File: reliability_supervisor.sv */
// Reliability supervisor: three watchdogs, backup stack CRC, link quality.
// Assumes radio-side event inputs are synchronous pulses/levels on pclk
// and an APB master on the register side.
//
// How it works
// - Implant side: wake-up receiver shut off when carrier or its clock is lost.
// - Wake-up receiver shut off if no start pattern within 2.5 packet widths.
// - Crystal failure or MAC start timeout: implant sleeps, base station restarts.
// - Established link terminated after 5 s without any header.
// - Warning interrupt raised 0.6 s before main watchdog shutdown.
// - Software kick restarts the main watchdog count.
// - In idle, serial-interface accesses keep the main watchdog alive.
// - MAC start automatically triggers a CRC check of the backup stack.
// - CRC covers every stack entry and can run whenever powered.
// - Check bit starts verification; pass and fail status report result.
// - Calc bit computes a fresh CRC word; done status set afterwards.
// - Copy-registers bit moves live settings into the backup stack.
// - Stack entries read and written singly through a stack address.
// - Counters for received, corrected and uncorrectable blocks.
// - After each packet, compare errors and retries to thresholds; interrupt.
// - Each block acknowledged or refused automatically from its CRC.
// - Every block checked by its own 12-bit CRC.
// - A watchdog is flagged active except after MAC start with no link, no idle and no wake-up pass running.
`timescale 1ns/100ps
module reliability_supervisor #(
  parameter int US_CYCLES  = reliability_pkg::US_CYCLES,
  parameter int MS_US      = reliability_pkg::MS_US,
  parameter int TIMEOUT_MS = reliability_pkg::MAIN_TIMEOUT_MS,
  parameter int WARN_MS    = reliability_pkg::WARN_LEAD_MS,
  parameter int INIT_MS    = reliability_pkg::INIT_TIMEOUT_MS,
  parameter int DEPTH      = reliability_pkg::STACK_DEPTH
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          implant_side,
  input  wire reliability_pkg::wake_in_t     wake_in,
  input  wire reliability_pkg::init_in_t     init_in,
  input  wire reliability_pkg::link_in_t     link_in,
  input  wire logic [DEPTH*8-1:0]            live_settings,
  output reliability_pkg::sup_out_t          sup_out
);

  localparam int AW = $clog2(DEPTH);

  // ------
  // State
  // ------
  typedef struct packed {
    logic [7:0]                us_div;
    logic [9:0]                ms_div;
    logic                      wake_busy;
    logic [17:0]               wake_cnt;
    logic                      init_busy;
    logic [15:0]               init_cnt;
    logic [15:0]               main_cnt;
    logic                      warned;
    reliability_pkg::crc_state_t crc_st;
    logic                      crc_op_check;
    logic [AW-1:0]             crc_idx;
    logic                      crc_pass;
    logic                      crc_fail;
    logic                      calc_done;
    logic [11:0]               crc_ref;
    logic [DEPTH-1:0][7:0]     stack;
    logic [AW-1:0]             stack_addr;
    logic [15:0]               wake_width;
    logic [7:0]                thr_err;
    logic [7:0]                thr_retx;
    logic [15:0]               cnt_rx;
    logic [15:0]               cnt_corr;
    logic [15:0]               cnt_err;
    logic [7:0]                pkt_err;
    logic                      blk_first;
    logic                      blk_eval;
    logic                      ack;
    logic [31:0]               rdata;
    logic                      slverr;
    reliability_pkg::sup_out_t out;
  } state_t;

  state_t st, next_st;

  logic [11:0] stack_crc;
  logic [11:0] blk_crc;
  logic        crc_init;
  logic        blk_init;

  // ------
  // CRC engines: one walks the backup stack, one checks incoming blocks
  // ------
  assign crc_init = (st.crc_st == reliability_pkg::CRC_IDLE);
  assign blk_init = st.blk_first;

  crc_engine #(
    .WIDTH (reliability_pkg::CRC_W),
    .POLY  (reliability_pkg::CRC12_POLY)
  ) u_stack_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .init    (crc_init),
    .valid   (st.crc_st == reliability_pkg::CRC_RUN),
    .data    (st.stack[st.crc_idx]),
    .crc     (stack_crc)
  );

  crc_engine #(
    .WIDTH (reliability_pkg::CRC_W),
    .POLY  (reliability_pkg::CRC12_POLY)
  ) u_block_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .init    (blk_init),
    .valid   (link_in.blk_valid),
    .data    (link_in.blk_byte),
    .crc     (blk_crc)
  );

  // ------
  // Next-state logic
  // ------
  always_comb begin
    logic        us_tick;
    logic        ms_tick;
    logic        setup;
    logic        wr_hit;
    logic [7:0]  wctl;
    logic [17:0] wake_limit;
    logic        main_arm;
    logic        main_kick;
    logic        start_chk;
    logic        start_calc;
    logic        clr_cnt;
    logic [31:0] rd;
    logic        hit;

    next_st  = st;
    rd       = '0;
    hit      = 1'b1;
    setup    = psel && !penable;
    wr_hit   = psel && penable && st.ack && pwrite;
    wctl     = (wr_hit && paddr == reliability_pkg::OFS_CTRL) ? pwdata[7:0] : 8'h00;
    clr_cnt  = wr_hit && paddr == reliability_pkg::OFS_CNT_RX;

    // Output pulses last one cycle
    next_st.out.wake_rx_off   = 1'b0;
    next_st.out.sleep_req     = 1'b0;
    next_st.out.restart_req   = 1'b0;
    next_st.out.link_shutdown = 1'b0;
    next_st.out.lq_irq        = 1'b0;
    next_st.out.blk_ack_valid = 1'b0;

    // Microsecond and millisecond enables, one divider chain
    us_tick = (st.us_div == 8'(US_CYCLES - 1));
    ms_tick = us_tick && (st.ms_div == 10'(MS_US - 1));
    next_st.us_div = us_tick ? 8'h00 : st.us_div + 8'h01;
    if (us_tick) begin
      next_st.ms_div = ms_tick ? 10'h000 : st.ms_div + 10'h001;
    end

    // Wake-up watchdog, implant side only
    wake_limit = {1'b0, st.wake_width, 1'b0} + {2'b00, st.wake_width[15:1]};
    if (implant_side && !(wake_in.carrier_ok && wake_in.clock_ok)) begin
      next_st.out.wake_rx_off = 1'b1;
      next_st.wake_busy       = 1'b0;
    end else if (implant_side && wake_in.wake_valid && !st.wake_busy) begin
      next_st.wake_busy = 1'b1;
      next_st.wake_cnt  = '0;
    end else if (st.wake_busy) begin
      if (wake_in.start_found) begin
        next_st.wake_busy = 1'b0;
      end else if (st.wake_cnt > wake_limit) begin
        next_st.out.wake_rx_off = 1'b1;
        next_st.wake_busy       = 1'b0;
      end else if (us_tick) begin
        next_st.wake_cnt = st.wake_cnt + 18'h00001;
      end
    end

    // Initialization watchdog: power-on until the MAC reports started
    if (init_in.mac_started) begin
      next_st.init_busy = 1'b0;
    end else if (init_in.xtal_fail || (st.init_busy && st.init_cnt >= 16'(INIT_MS))) begin
      next_st.init_busy       = 1'b0;
      next_st.out.sleep_req   = implant_side;
      next_st.out.restart_req = !implant_side;
    end else if (init_in.mac_power_on) begin
      next_st.init_busy = 1'b1;
      next_st.init_cnt  = '0;
    end else if (st.init_busy && ms_tick) begin
      next_st.init_cnt = st.init_cnt + 16'h0001;
    end

    // Main watchdog: headers on a link, serial traffic in idle, software kick
    main_arm  = link_in.link_up || link_in.idle;
    main_kick = wctl[reliability_pkg::CTRL_WD_KICK]
              || (link_in.link_up && link_in.header_rx)
              || (link_in.idle && link_in.spi_access);
    if (!main_arm || main_kick) begin
      next_st.main_cnt        = '0;
      next_st.warned          = 1'b0;
      next_st.out.wd_warn_irq = 1'b0;
    end else if (st.main_cnt >= 16'(TIMEOUT_MS)) begin
      next_st.out.link_shutdown = 1'b1;
      next_st.out.sleep_req     = implant_side;
      next_st.out.wd_warn_irq   = 1'b0;
      next_st.main_cnt          = '0;
      next_st.warned            = 1'b0;
    end else begin
      if (ms_tick) begin
        next_st.main_cnt = st.main_cnt + 16'h0001;
      end
      if (!st.warned && st.main_cnt >= 16'(TIMEOUT_MS - WARN_MS)) begin
        next_st.warned          = 1'b1;
        next_st.out.wd_warn_irq = 1'b1;
      end
    end

    // Active while any watchdog runs or the MAC has not yet started
    next_st.out.wd_active = main_arm || next_st.init_busy || next_st.wake_busy
                          || !init_in.mac_started;

    // Backup stack CRC sequencer; a running pass ignores new requests
    start_chk  = wctl[reliability_pkg::CTRL_CRC_CHECK] || init_in.mac_started;
    start_calc = wctl[reliability_pkg::CTRL_CRC_CALC];
    case (st.crc_st)
      reliability_pkg::CRC_IDLE: begin
        if (start_chk || start_calc) begin
          next_st.crc_st       = reliability_pkg::CRC_RUN;
          next_st.crc_op_check = !start_calc;
          next_st.crc_idx      = '0;
          next_st.crc_pass     = 1'b0;
          next_st.crc_fail     = 1'b0;
          next_st.calc_done    = 1'b0;
          next_st.out.crc_error = 1'b0;
        end
      end
      reliability_pkg::CRC_RUN: begin
        next_st.crc_idx = st.crc_idx + AW'(1);
        if (st.crc_idx == AW'(DEPTH - 1)) begin
          next_st.crc_st = reliability_pkg::CRC_EVAL;
        end
      end
      reliability_pkg::CRC_EVAL: begin
        next_st.crc_st = reliability_pkg::CRC_IDLE;
        if (st.crc_op_check) begin
          next_st.crc_pass      = (stack_crc == st.crc_ref);
          next_st.crc_fail      = (stack_crc != st.crc_ref);
          next_st.out.crc_error = (stack_crc != st.crc_ref);
        end else begin
          next_st.crc_ref   = stack_crc;
          next_st.calc_done = 1'b1;
        end
      end
      default: next_st.crc_st = reliability_pkg::CRC_IDLE;
    endcase

    // Copy of live settings; held off while the CRC walks the stack
    if (wctl[reliability_pkg::CTRL_COPY_REGS] && st.crc_st == reliability_pkg::CRC_IDLE) begin
      for (int i = 0; i < DEPTH; i++) begin
        next_st.stack[i] = live_settings[i*8 +: 8];
      end
    end

    // Block check: remainder over data and CRC is zero for a clean block
    if (link_in.blk_valid) begin
      next_st.blk_first = link_in.blk_last;
    end
    next_st.blk_eval = link_in.blk_valid && link_in.blk_last;
    if (clr_cnt) begin
      next_st.cnt_rx   = '0;
      next_st.cnt_corr = '0;
      next_st.cnt_err  = '0;
    end
    // Increments come after the clear so a coinciding event is kept
    if (st.blk_eval) begin
      next_st.out.blk_ack_valid = 1'b1;
      next_st.out.blk_ack_ok    = (blk_crc == 12'h000);
      next_st.cnt_rx = next_st.cnt_rx + 16'h0001;
      if (blk_crc != 12'h000) begin
        next_st.cnt_err = next_st.cnt_err + 16'h0001;
        next_st.pkt_err = (st.pkt_err == 8'hFF) ? st.pkt_err : st.pkt_err + 8'h01;
      end
    end
    if (link_in.blk_corrected) begin
      next_st.cnt_corr = next_st.cnt_corr + 16'h0001;
    end

    // Per-packet quality evaluation
    if (link_in.pkt_end) begin
      next_st.out.lq_irq = (st.pkt_err > st.thr_err)
                         || (link_in.retx > st.thr_retx);
      next_st.pkt_err    = '0;
    end

    // Register reads, latched in the setup cycle
    case (paddr)
      reliability_pkg::OFS_CTRL:       rd = '0;
      reliability_pkg::OFS_STATUS: begin
        rd[reliability_pkg::STS_CRC_PASS]  = st.crc_pass;
        rd[reliability_pkg::STS_CRC_FAIL]  = st.crc_fail;
        rd[reliability_pkg::STS_CALC_DONE] = st.calc_done;
        rd[reliability_pkg::STS_WD_WARN]   = st.warned;
        rd[reliability_pkg::STS_CRC_BUSY]  = (st.crc_st != reliability_pkg::CRC_IDLE);
        rd[reliability_pkg::STS_MAIN_ARM]  = main_arm;
        rd[reliability_pkg::STS_WD_ACTIVE] = st.out.wd_active;
      end
      reliability_pkg::OFS_STACK_ADDR: rd = 32'(st.stack_addr);
      reliability_pkg::OFS_STACK_DATA: rd = {24'h000000, st.stack[st.stack_addr]};
      reliability_pkg::OFS_CRC_WORD:   rd = {20'h00000, st.crc_ref};
      reliability_pkg::OFS_WAKE_WIDTH: rd = {16'h0000, st.wake_width};
      reliability_pkg::OFS_THRESH:     rd = {16'h0000, st.thr_retx, st.thr_err};
      reliability_pkg::OFS_CNT_RX:     rd = {16'h0000, st.cnt_rx};
      reliability_pkg::OFS_CNT_CORR:   rd = {16'h0000, st.cnt_corr};
      reliability_pkg::OFS_CNT_ERR:    rd = {16'h0000, st.cnt_err};
      default:                         hit = 1'b0;
    endcase
    if (setup) begin
      next_st.ack    = 1'b1;
      next_st.rdata  = pwrite ? 32'h00000000 : rd;
      next_st.slverr = !hit;
    end else if (psel && penable && st.ack) begin
      next_st.ack    = 1'b0;
      next_st.slverr = 1'b0;
    end

    // Register writes, taken at the completing access edge
    if (wr_hit) begin
      case (paddr)
        reliability_pkg::OFS_STACK_ADDR: next_st.stack_addr = pwdata[AW-1:0];
        reliability_pkg::OFS_STACK_DATA: begin
          if (st.crc_st == reliability_pkg::CRC_IDLE) begin
            next_st.stack[st.stack_addr] = pwdata[7:0];
          end
        end
        reliability_pkg::OFS_CRC_WORD:   next_st.crc_ref    = pwdata[11:0];
        reliability_pkg::OFS_WAKE_WIDTH: next_st.wake_width = pwdata[15:0];
        reliability_pkg::OFS_THRESH: begin
          next_st.thr_err  = pwdata[7:0];
          next_st.thr_retx = pwdata[15:8];
        end
        default: ;
      endcase
    end
  end

  // ------
  // State register
  // ------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st            <= '0;
      st.crc_st     <= reliability_pkg::CRC_IDLE;
      st.wake_width <= reliability_pkg::WAKE_WIDTH_RST;
      st.thr_err    <= reliability_pkg::THR_ERR_RST;
      st.thr_retx   <= reliability_pkg::THR_RETX_RST;
      st.blk_first  <= 1'b1;
      st.out.wd_active <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------
  // Outputs
  // ------
  // Zero-wait-state slave: pready is the flop set in the setup cycle
  assign prdata  = st.rdata;
  assign pready  = st.ack;
  assign pslverr = st.slverr && st.ack;
  assign sup_out = st.out;

endmodule : reliability_supervisor

/* File: reliability_supervisor_chk.sv */
// Checker for the supervisor's register bus and event outputs.
// Assumes it is bound to the supervisor and sees its ports only.
`timescale 1ns/100ps
module reliability_supervisor_chk (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic                      implant_side,
  input wire reliability_pkg::wake_in_t wake_in,
  input wire reliability_pkg::init_in_t init_in,
  input wire reliability_pkg::link_in_t link_in,
  input wire logic [127:0]              live_settings,
  input wire reliability_pkg::sup_out_t sup_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero-wait answer, and never outside an access
  apb_ready_a: assert property (psel && !penable |=> pready && psel && penable) else $error("late pready");
  apb_only_a: assert property (pready |-> psel && penable) else $error("stray pready");
  apb_err_a: assert property (pready && paddr > 8'h24 |-> pslverr && prdata == 32'h0) else $error("unmapped");
  wake_off_a: assert property (implant_side && !wake_in.carrier_ok && !wake_in.clock_ok |=> sup_out.wake_rx_off) else $error("wake rx on");
  wd_on_a: assert property (sup_out.wd_active) else $error("no watchdog");
  shut_sleep_a: assert property (sup_out.link_shutdown && implant_side |-> sup_out.sleep_req) else $error("no sleep");
  warn_first_a: assert property (sup_out.link_shutdown |-> $past(sup_out.wd_warn_irq)) else $error("no warning");
  lq_pkt_a: assert property (sup_out.lq_irq |-> $past(link_in.pkt_end)) else $error("stray lq irq");
  ack_blk_a: assert property (sup_out.blk_ack_valid |-> $past(link_in.blk_last && link_in.blk_valid, 2)) else $error("stray ack");
  base_rst_a: assert property (sup_out.restart_req |-> !implant_side) else $error("restart");
endmodule : reliability_supervisor_chk
bind reliability_supervisor reliability_supervisor_chk i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .implant_side(implant_side),
  .wake_in(wake_in), .init_in(init_in), .link_in(link_in), .live_settings(live_settings),
  .sup_out(sup_out));

/* File: apb_host.sv */
// Application processor model: an APB master with one transfer task.
// Assumes callers stand just after a rising edge; waits are bounded by the bench.
`timescale 1ns/100ps
module apb_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // Setup, then hold until pready; an edge passes first so strobes never clash
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0; pwdata <= ~d;
  endtask : xfer
endmodule : apb_host

/* File: tb_reliability_supervisor.sv */
// Self-checking bench for the reliability supervisor, short watchdog counts.
// Assumes the package, the design, the checker and the APB host model.
`timescale 1ns/100ps
module tb_reliability_supervisor;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, implant_side, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [127:0] live;
  reliability_pkg::wake_in_t wake_in;
  reliability_pkg::init_in_t init_in;
  reliability_pkg::link_in_t link_in;
  reliability_pkg::sup_out_t sup_out;
  int n_fail, cmp_count, cyc, n;
  // 1 ms is 16 cycles here, so warn near 240 and shutdown near 320
  reliability_supervisor #(.US_CYCLES(4), .MS_US(4), .TIMEOUT_MS(20), .WARN_MS(5), .INIT_MS(5))
    i_reliability_supervisor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .implant_side(implant_side), .wake_in(wake_in), .init_in(init_in),
    .link_in(link_in), .live_settings(live), .sup_out(sup_out));
  apb_host i_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_apb_host.xfer(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    i_apb_host.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp, m);
  endtask : rdchk
  function automatic logic [11:0] crc_upd(input logic [11:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[10:0], 1'b0} ^ ((c[11] ^ b[i]) ? 12'h80F : 12'h000);
    return c;
  endfunction : crc_upd
  // Awaits an output going high: 0 warn level, 1 shutdown, 2 block ack, 3 lq irq
  task automatic wait_ev(input int s, input int lim);
    logic [3:0] ev;
    for (n = 1; n < lim; n++) begin
      @(posedge pclk);
      ev = {sup_out.lq_irq, sup_out.blk_ack_valid, sup_out.link_shutdown, sup_out.wd_warn_irq};
      if (ev[s] === 1'b1) break;
    end
  endtask : wait_ev
  task automatic t_regs;
    rdchk(reliability_pkg::OFS_WAKE_WIDTH, 32'h000003E8, "wake width reset");
    rdchk(reliability_pkg::OFS_THRESH, 32'h00000404, "threshold reset");
    rdchk(8'h40, 32'h00000000, "unmapped data");
    chk({31'h0, er}, 32'h1, "unmapped error");
  endtask : t_regs
  task automatic t_crc;
    logic [11:0] c;
    c = 12'h000;
    for (int i = 0; i < 16; i++) c = crc_upd(c, (i == 3) ? 8'hA5 : 8'h00);
    wr(reliability_pkg::OFS_STACK_ADDR, 32'h3);
    wr(reliability_pkg::OFS_STACK_DATA, 32'hA5);
    rdchk(reliability_pkg::OFS_STACK_DATA, 32'hA5, "stack entry");
    wr(reliability_pkg::OFS_CTRL, 32'h4);
    repeat (20) @(posedge pclk);
    rdchk(reliability_pkg::OFS_CRC_WORD, {20'h0, c}, "crc word");
    rdchk(reliability_pkg::OFS_STATUS, 32'h44, "calc done");
    for (int k = 0; k < 2; k++) begin
      wr(reliability_pkg::OFS_CTRL, 32'h2);
      repeat (20) @(posedge pclk);
      chk({31'h0, sup_out.crc_error}, k, "crc error out");
      rdchk(reliability_pkg::OFS_STATUS, k ? 32'h42 : 32'h41, "status");
      chk({30'h0, rd[1:0]}, k ? 32'h2 : 32'h1, "check result");
      wr(reliability_pkg::OFS_STACK_DATA, 32'h5A);
    end
    wr(reliability_pkg::OFS_CTRL, 32'h8);
    rdchk(reliability_pkg::OFS_STACK_DATA, 32'hC3, "copied entry");
  endtask : t_crc
  task automatic t_block(input logic bad);
    logic [11:0] c;
    c = 12'h000;
    for (int i = 0; i < 16; i++) begin
      if (i < 14) c = crc_upd(c, 8'(i + 1));
      link_in.blk_valid <= 1'b1;
      link_in.blk_last <= (i == 15);
      link_in.blk_byte <= (i < 14) ? 8'(i + 1) ^ {7'h0, bad} : (i == 14) ? c[11:4] : {c[3:0], 4'h0};
      @(posedge pclk);
    end
    link_in.blk_valid <= 1'b0;
    link_in.blk_last <= 1'b0;
    wait_ev(2, 6);
    chk({31'h0, sup_out.blk_ack_ok}, {31'h0, ~bad}, "block ack");
  endtask : t_block
  task automatic t_link;
    wr(reliability_pkg::OFS_THRESH, 32'h0);
    t_block(1'b0);
    t_block(1'b1);
    link_in.blk_corrected <= 1'b1;
    link_in.pkt_end <= 1'b1;
    @(posedge pclk);
    link_in.blk_corrected <= 1'b0;
    link_in.pkt_end <= 1'b0;
    wait_ev(3, 4);
    chk({31'h0, sup_out.lq_irq}, 32'h1, "link quality irq");
    rdchk(reliability_pkg::OFS_CNT_RX, 32'h2, "received blocks");
    rdchk(reliability_pkg::OFS_CNT_CORR, 32'h1, "corrected blocks");
    rdchk(reliability_pkg::OFS_CNT_ERR, 32'h1, "error blocks");
  endtask : t_link
  task automatic t_watchdog;
    wake_in <= 4'b0000;
    link_in.link_up <= 1'b1;
    link_in.header_rx <= 1'b1;
    @(posedge pclk);
    wake_in <= 4'b1100;
    link_in.header_rx <= 1'b0;
    wait_ev(0, 400);
    chk({31'h0, n >= 224 && n <= 260}, 32'h1, "warning lead");
    wr(reliability_pkg::OFS_CTRL, 32'h1);
    @(posedge pclk);
    chk({31'h0, sup_out.wd_warn_irq}, 32'h0, "kick clears warning");
    wait_ev(1, 400);
    chk({31'h0, n >= 300 && n <= 340}, 32'h1, "shutdown time");
    link_in.link_up <= 1'b0;
  endtask : t_watchdog
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // Hang guard, well above the fewer than a thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    presetn = 1'b0;
    implant_side = 1'b1;
    wake_in = 4'b1100;
    init_in = '0;
    link_in = '0;
    live = {16{8'hC3}};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, sup_out.wd_active}, 32'h1, "watchdog active");
    t_regs();
    t_crc();
    t_link();
    t_watchdog();
    conclude();
  end
endmodule : tb_reliability_supervisor
